// file: hw/rxsg_top.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module rxsg_top
	import rxsg_pkg::*;
#(
	parameter int ADDR_W = 18
)
(
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	input  wire rxsg_sigs_t        sigs_i,
	input  wire rxsg_pin_t         signal_input_pin_i,
	input  wire logic              internal_mod_i,
	input  wire logic              rx_raw_i,
	input  wire logic              bit_tick_i,
	input  wire logic              tx_last_mod_i,
	input  wire logic              ext_field_on_i,
	input  wire logic              cmd_start_i,
	input  wire logic              cmd_is_receive_i,
	output logic                   signal_output_pin_o,
	output logic                   decoder_in_o,
	output logic                   rx_gated_o,
	output logic                   rx_enable_o
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] rx_sel_q;
	logic [3:0] out_sel_q;
	logic [1:0] ctrl_q;
	logic [5:0] guard_cnt_q;
	logic       guard_busy_q;
	logic       guard_armed_q;
	rxsg_pin_t  pin_s1_q;
	rxsg_pin_t  pin_s2_q;
	logic       field_s1_q;
	logic       field_s2_q;
	logic       field_prev_q;

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	logic              aw_held_q;
	logic              w_held_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              wr_fire;
	logic              wr_hit;

	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid_o;

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			aw_held_q <= 1'b0;
			awaddr_q  <= '0;
		end
		else if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			aw_held_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr_i;
		end
		else if (wr_fire)
			aw_held_q <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			w_held_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end
		else if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata_i;
			wstrb_q  <= s_axi_wstrb_i;
		end
		else if (wr_fire)
			w_held_q <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
		end
		else
		begin
			s_axi_awready_o <= !aw_held_q && !(s_axi_awvalid_i && s_axi_awready_o)
				&& !s_axi_bvalid_o;
			s_axi_wready_o  <= !w_held_q && !(s_axi_wvalid_i && s_axi_wready_o)
				&& !s_axi_bvalid_o;
		end
	end

	assign wr_hit = awaddr_q[17:0] == RXSG_RX_SEL_ADDR
		|| awaddr_q[17:0] == RXSG_OUT_SEL_ADDR
		|| awaddr_q[17:0] == RXSG_CTRL_ADDR;

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RXSG_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_hit ? RXSG_RESP_OKAY : RXSG_RESP_SLVERR;
		end
		else if (s_axi_bready_i)
			s_axi_bvalid_o <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			rx_sel_q  <= RXSG_RX_SEL_RST;
			out_sel_q <= RXSG_OUT_SEL_RST;
			ctrl_q    <= '0;
		end
		else if (wr_fire && wstrb_q[0])
		begin
			if (awaddr_q[17:0] == RXSG_RX_SEL_ADDR)
				rx_sel_q <= wdata_q[7:0];
			if (awaddr_q[17:0] == RXSG_OUT_SEL_ADDR)
				out_sel_q <= wdata_q[3:0];
			if (awaddr_q[17:0] == RXSG_CTRL_ADDR)
				ctrl_q <= wdata_q[1:0];
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= RXSG_RESP_OKAY;
		end
		else if (s_axi_rvalid_o)
		begin
			s_axi_arready_o <= 1'b0;
			if (s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= RXSG_RESP_OKAY;
			unique case (s_axi_araddr_i[17:0])
				RXSG_RX_SEL_ADDR:
					s_axi_rdata_o <= {24'h000000, rx_sel_q};
				RXSG_OUT_SEL_ADDR:
					s_axi_rdata_o <= {28'h0000000, out_sel_q};
				RXSG_CTRL_ADDR:
					s_axi_rdata_o <= {30'h0, ctrl_q};
				RXSG_STAT_ADDR:
					s_axi_rdata_o <= {24'h000000, guard_busy_q, rx_enable_o,
						guard_cnt_q};
				default:
				begin
					s_axi_rdata_o <= '0;
					s_axi_rresp_o <= RXSG_RESP_SLVERR;
				end
			endcase
		end
		else
			s_axi_arready_o <= 1'b1;
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			pin_s1_q   <= '0;
			pin_s2_q   <= '0;
			field_s1_q <= 1'b0;
			field_s2_q <= 1'b0;
		end
		else
		begin
			pin_s1_q   <= signal_input_pin_i;
			pin_s2_q   <= pin_s1_q;
			field_s1_q <= ext_field_on_i;
			field_s2_q <= field_s1_q;
		end
	end

	// ------------------------------------------------------------
	// receive guard
	// ------------------------------------------------------------
	logic guard_start;
	assign guard_start = ctrl_q[RXSG_CTRL_ACTIVE]
		? field_s2_q && !field_prev_q
		: tx_last_mod_i;

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			guard_armed_q <= 1'b0;
		else if (cmd_start_i)
			guard_armed_q <= !cmd_is_receive_i;
		else if (guard_start)
			guard_armed_q <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			guard_cnt_q  <= '0;
			guard_busy_q <= 1'b0;
			field_prev_q <= 1'b0;
			rx_enable_o  <= 1'b1;
		end
		else
		begin
			field_prev_q <= field_s2_q;
			if (cmd_start_i)
			begin
				guard_busy_q <= 1'b0;
				rx_enable_o  <= cmd_is_receive_i;
			end
			else if (guard_start && guard_armed_q)
			begin
				guard_cnt_q  <= rx_sel_q[RXSG_DLY_MSB:0];
				guard_busy_q <= rx_sel_q[RXSG_DLY_MSB:0] != 6'h00;
				rx_enable_o  <= rx_sel_q[RXSG_DLY_MSB:0] == 6'h00;
			end
			else if (guard_busy_q && bit_tick_i)
			begin
				guard_cnt_q <= guard_cnt_q - 6'h01;
				if (guard_cnt_q == 6'h01)
				begin
					guard_busy_q <= 1'b0;
					rx_enable_o  <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// signal routing
	// ------------------------------------------------------------
	logic dec_d;
	logic out_d;

	always_comb
	begin
		unique case (rx_sel_q[7:RXSG_SRC_LSB])
			2'b00: dec_d = 1'b0;
			2'b01: dec_d = pin_s2_q.env;
			2'b10: dec_d = internal_mod_i;
			2'b11: dec_d = pin_s2_q.mod;
		endcase
	end

	always_comb
	begin
		unique case (out_sel_q)
			4'h1: out_d = 1'b0;
			4'h2: out_d = 1'b1;
			4'h3: out_d = sigs_i.test_bit;
			4'h4: out_d = sigs_i.coder_env;
			4'h5: out_d = sigs_i.tx_data;
			4'h6: out_d = sigs_i.rx_delayed;
			4'h7: out_d = sigs_i.rx_data;
			4'h8: out_d = sigs_i.rx_regen;
			4'h9: out_d = sigs_i.tx;
			4'hA: out_d = sigs_i.comparator;
			4'hC: out_d = sigs_i.rx_carrier;
			4'hD: out_d = sigs_i.tx_carrier;
			4'hE: out_d = sigs_i.rx_carrier_raw;
			4'hF: out_d = sigs_i.env_raw;
			default: out_d = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			signal_output_pin_o <= 1'b0;
			decoder_in_o        <= 1'b0;
			rx_gated_o          <= 1'b0;
		end
		else
		begin
			signal_output_pin_o <= out_d;
			decoder_in_o        <= dec_d & rx_enable_o;
			rx_gated_o          <= rx_raw_i & rx_enable_o;
		end
	end

endmodule
`default_nettype wire

// file: hw/rxsg_pkg.sv
// Notes on behaviour
// - codes 1000 regenerated rx, 1001 tx, 1010 comparator, 1011 reserved drives low.
// - codes 1100 rx+carrier, 1101 tx+carrier, 1110 raw rx+carrier, 1111 raw envelope.
// - decoder source: 00 low, 01 pin envelope, 10 internal, 11 pin modulation.
// - after transmit, receive input is ignored for guard delay bit periods.
// - plain receive skips the guard; every other command applies it.
// - passive mode: guard starts at the last transmitted modulation.
// - active mode: guard starts when the external field switches on.
// - receiver input select fully read/write, reset source 10, delay 4.
// - codes 0001 low, 0010 high, 0011 test bit, 0100 envelope, 0101 tx data.
// - code 0110 regenerated delayed rx, 0111 received serial data.
package rxsg_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [15:0] RXSG_RX_SEL_IDX  = 16'h6307;
	localparam logic [17:0] RXSG_RX_SEL_ADDR = {RXSG_RX_SEL_IDX, 2'b00};
	localparam logic [17:0] RXSG_OUT_SEL_ADDR = 18'h00100;
	localparam logic [17:0] RXSG_CTRL_ADDR   = 18'h00104;
	localparam logic [17:0] RXSG_STAT_ADDR   = 18'h00108;
	localparam logic [7:0]  RXSG_RX_SEL_RST  = 8'h84;
	localparam logic [3:0]  RXSG_OUT_SEL_RST = 4'h0;
	localparam int          RXSG_SRC_LSB     = 6;
	localparam int          RXSG_DLY_MSB     = 5;
	localparam int          RXSG_CTRL_ACTIVE = 0;
	localparam int          RXSG_CTRL_RCV    = 1;
	localparam logic [1:0]  RXSG_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RXSG_RESP_SLVERR = 2'b10;

	typedef struct packed
	{
		logic rx_regen;
		logic tx;
		logic comparator;
		logic rx_carrier;
		logic tx_carrier;
		logic rx_carrier_raw;
		logic env_raw;
		logic test_bit;
		logic coder_env;
		logic tx_data;
		logic rx_delayed;
		logic rx_data;
	} rxsg_sigs_t;

	typedef struct packed
	{
		logic env;
		logic mod;
	} rxsg_pin_t;

endpackage

// file: testbench/rxsg_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rxsg_chk
(
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        rx_raw_i,
	input wire logic        cmd_start_i,
	input wire logic        cmd_is_receive_i,
	input wire logic        decoder_in_o,
	input wire logic        rx_gated_o,
	input wire logic        rx_enable_o
);
	// ----
	// port relations
	// ----
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	gated_needs_raw_a:
		assert property (rx_gated_o |-> $past(rx_raw_i))
		else $error("gated rx without raw rx");
	guard_blocks_a:
		assert property ($past(!rx_enable_o) && !rx_enable_o
			|-> !rx_gated_o && !decoder_in_o)
		else $error("receive input passed during guard");
	cmd_guard_a:
		assert property (cmd_start_i && !cmd_is_receive_i |=> !rx_enable_o)
		else $error("guard not applied");
	receive_no_guard_a:
		assert property (cmd_start_i && cmd_is_receive_i ##1 1 |-> rx_enable_o)
		else $error("receive command guarded");
	bresp_hold_a:
		assert property (s_axi_bvalid_o && !s_axi_bready_i
			|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	rdata_hold_a:
		assert property (s_axi_rvalid_o && !s_axi_rready_i
			|=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped");
	read_answer_a:
		assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	reset_state_a:
		assert property (disable iff (1'b0) rst_i
			|=> rx_enable_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
		else $error("bad reset state");
endmodule
bind rxsg_top rxsg_chk chk (.*);
`default_nettype wire

// file: testbench/rxsg_front.sv
`timescale 1ns/10ps
`default_nettype none
module rxsg_front
(
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic send_i,
	input  wire logic field_i,
	input  wire logic tick_en_i,
	output logic      bit_tick_o,
	output logic      tx_last_mod_o,
	output logic      ext_field_on_o,
	output logic      rx_raw_o
);
	// ----
	// front end
	// ----
	logic [1:0] ph_q;
	always_ff @(posedge clock_i)
	begin
		ph_q <= rst_i ? 2'h0 : ph_q + 2'h1;
		bit_tick_o <= tick_en_i && ph_q == 2'h3;
		tx_last_mod_o <= send_i;
		ext_field_on_o <= field_i;
		rx_raw_o <= rst_i ? 1'b0 : !rx_raw_o;
	end
endmodule
`default_nettype wire

// file: testbench/tb_rx_source_select_and_guard.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rx_source_select_and_guard;
	import rxsg_pkg::*;
	logic        clock_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i;
	logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_arready_o, s_axi_rvalid_o, internal_mod_i;
	logic        rx_raw_i, bit_tick_i, tx_last_mod_i, ext_field_on_i;
	logic        cmd_start_i, cmd_is_receive_i, signal_output_pin_o;
	logic        decoder_in_o, rx_gated_o, rx_enable_o, send, field;
	logic        tick_en;
	logic [17:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
	logic [3:0]  s_axi_wstrb_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rs, br;
	logic [11:0] m;
	rxsg_sigs_t  sigs_i;
	rxsg_pin_t   signal_input_pin_i;
	int          err_count, samples_checked, cyc, c, v;
	int          map [16] = '{12, 12, 13, 4, 3, 2, 1, 0, 11, 10, 9, 12, 8, 7, 6, 5};

	rxsg_top dut (.*);
	rxsg_front fe (.clock_i, .rst_i, .send_i(send), .field_i(field),
		.tick_en_i(tick_en), .bit_tick_o(bit_tick_i),
		.tx_last_mod_o(tx_last_mod_i), .ext_field_on_o(ext_field_on_i),
		.rx_raw_o(rx_raw_i));

	// ----
	// helpers
	// ----
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task end_of_test;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wr(input logic [17:0] a, input logic [31:0] d);
		@(posedge clock_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do
		begin
			@(posedge clock_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o)
			begin
				br = s_axi_bresp_o;
				s_axi_bready_i <= 1'b0;
			end
		end while (s_axi_bready_i);
	endtask
	task rdr(input logic [17:0] a);
		@(posedge clock_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do
		begin
			@(posedge clock_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o)
			begin
				rd = s_axi_rdata_o;
				rs = s_axi_rresp_o;
				s_axi_rready_i <= 1'b0;
			end
		end while (s_axi_rready_i);
	endtask
	task cmd(input logic r);
		@(posedge clock_i);
		cmd_start_i <= 1'b1;
		cmd_is_receive_i <= r;
		@(posedge clock_i);
		cmd_start_i <= 1'b0;
		@(negedge clock_i);
	endtask
	task guard(input logic [5:0] d, input logic a);
		int n;
		int k;
		n = 0;
		wr(RXSG_RX_SEL_ADDR, 32'({2'b10, d}));
		wr(RXSG_CTRL_ADDR, 32'(a));
		cmd(1'b0);
		chk(32'(rx_enable_o), 32'h0);
		@(posedge clock_i);
		if (a) field <= 1'b1;
		else send <= 1'b1;
		@(posedge clock_i);
		send <= 1'b0;
		repeat (6) @(posedge clock_i);
		rdr(RXSG_STAT_ADDR);
		chk(rd, 32'({d != 6'h00, d == 6'h00, d}));
		tick_en <= 1'b1;
		@(negedge clock_i);
		for (k = 0; k < 400 && !rx_enable_o; k++)
		begin
			@(negedge clock_i);
			if (!rx_enable_o && bit_tick_i) n++;
		end
		chk(32'(n), 32'(d));
		@(negedge clock_i);
		chk(32'(rx_gated_o), 32'(!rx_raw_i));
		@(posedge clock_i);
		tick_en <= 1'b0;
		field <= 1'b0;
	endtask

	initial
	begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_count++;
			end_of_test;
		end
	end

	// ----
	// main sequence
	// ----
	initial
	begin
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
		{s_axi_arvalid_i, s_axi_rready_i, internal_mod_i} = 3'h0;
		{cmd_start_i, cmd_is_receive_i, send, field, tick_en} = 5'h0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 68'h0;
		s_axi_wstrb_i = 4'hF;
		sigs_i = 12'h000;
		signal_input_pin_i = 2'h0;
		rst_i = 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		for (c = 0; c < 16; c++)
		begin
			wr(RXSG_OUT_SEL_ADDR, 32'(c));
			m = map[c] < 12 ? 12'h001 << map[c] : 12'h000;
			for (v = 0; v < 2; v++)
			begin
				sigs_i <= v ? ~m : m;
				repeat (3) @(posedge clock_i);
				chk(32'(signal_output_pin_o), 32'(v ? map[c] == 13 : map[c] != 12));
			end
		end
		rdr(RXSG_RX_SEL_ADDR);
		chk(rd, 32'h84);
		for (v = 0; v < 2; v++)
		begin
			wr(RXSG_RX_SEL_ADDR, v ? 32'hA5 : 32'h5A);
			rdr(RXSG_RX_SEL_ADDR);
			chk(rd, v ? 32'hA5 : 32'h5A);
		end
		rdr(18'h00200);
		chk(rd, 32'h0);
		chk(32'(rs), 32'(RXSG_RESP_SLVERR));
		wr(18'h00200, 32'h1);
		chk(32'(br), 32'(RXSG_RESP_SLVERR));
		for (c = 0; c < 4; c++)
		begin
			wr(RXSG_RX_SEL_ADDR, 32'({c[1:0], 6'h04}));
			for (v = 0; v < 2; v++)
			begin
				internal_mod_i <= (c == 2) == v;
				signal_input_pin_i.env <= (c == 1) == v;
				signal_input_pin_i.mod <= (c == 3) == v;
				repeat (5) @(posedge clock_i);
				chk(32'(decoder_in_o), 32'(c != 0 && v != 0));
			end
		end
		cmd(1'b0);
		cmd(1'b1);
		chk(32'(rx_enable_o), 32'h1);
		guard(6'd3, 1'b0);
		guard(6'd0, 1'b0);
		guard(6'd63, 1'b1);
		guard(6'd1, 1'b1);
		cmd(1'b0);
		@(posedge clock_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rdr(RXSG_STAT_ADDR);
		chk(rd, 32'h00000040);
		rdr(RXSG_RX_SEL_ADDR);
		chk(rd, 32'(RXSG_RX_SEL_RST));
		end_of_test;
	end
endmodule
`default_nettype wire
